// File: hw/fan_monitor_pkg.sv
package fan_monitor_pkg;

    // ==========================================
    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int FILT_HZ = 32_000;
    localparam int FILT_US = 750;
    localparam int TICK_CYCLES = CLK_HZ / FILT_HZ;
    // one spare tick, so a pulse shorter than the window never spans it
    localparam int FILT_TICKS = (FILT_US * FILT_HZ + 999_999) / 1_000_000 + 1;
    localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
    localparam logic [4:0] FILT_LAST = 5'(FILT_TICKS - 1);

    // ==========================================
    // register map (byte addresses)
    localparam logic [31:0] ADDR_LIMIT = 32'h0000_0000;
    localparam logic [31:0] ADDR_SPEED = 32'h0000_0004;
    localparam logic [31:0] ADDR_CSR = 32'h0000_0008;
    localparam logic [31:0] ADDR_ENABLE = 32'h0000_000c;

    // ==========================================
    // field positions
    localparam int CSR_SEL_LSB = 5;
    localparam int CSR_FILT_DIS = 4;
    localparam int CSR_IE = 3;
    localparam int CSR_OVF = 2;
    localparam int CSR_OVTH = 1;
    localparam int CSR_RDY = 0;
    localparam int EN_BIT = 0;

    // ==========================================
    // reset values and answers
    localparam logic [7:0] LIMIT_RST = 8'hff;
    localparam logic [7:0] SPEED_RST = 8'h00;
    localparam logic [1:0] CLKSEL_RST = 2'h1;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================
    // types
    typedef enum logic [1:0] {
        MON_OFF = 2'h0,
        MON_ARM = 2'h1,
        MON_RUN = 2'h3
    } mon_state_type;

    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_LIMIT = 3'h1,
        SEL_SPEED = 3'h2,
        SEL_CSR = 3'h3,
        SEL_EN = 3'h4
    } reg_sel_type;

    typedef struct packed {
        logic [31:0] awaddr;
        logic [2:0] awprot;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic [2:0] arprot;
        logic arvalid;
        logic rready;
    } axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_type;

    typedef struct packed {
        axi_rsp_type rsp;
        logic aw_got;
        logic w_got;
        logic [31:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        mon_state_type mon;
        logic [7:0] cnt;
        logic [7:0] speed;
        logic [7:0] limit;
        logic [1:0] clksel;
        logic filt_dis;
        logic ie;
        logic ovf;
        logic ovth;
        logic rdy;
        logic block;
        logic en;
        logic irq;
        logic [2:0] sync;
        logic level;
        logic filt;
        logic [4:0] fcnt;
        logic prev;
        logic [11:0] pre;
        logic [3:0] div;
    } state_type;

endpackage

// File: hw/fan_tach_speed_monitor.sv
`timescale 1ns/1ps
module fan_tach_speed_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire fan_monitor_pkg::axi_req_type axi_req,
    output fan_monitor_pkg::axi_rsp_type axi_rsp,
    input wire logic tach_pulse_input,
    output logic speed_alert_irq
);
    import fan_monitor_pkg::*;

    state_type q;
    state_type d;
    logic ftick;
    logic cnt_tick;
    logic [3:0] div_mask;
    logic clean;
    logic rise;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_fire;
    logic rd_speed;
    logic ovf_evt;
    logic latch;
    logic wr_ok;
    reg_sel_type wsel;
    reg_sel_type rsel;
    logic [7:0] csr_rd;

    // ==========================================
    // address decode

    // maps a byte address onto a register select
    function automatic reg_sel_type reg_sel(input logic [31:0] a);
        reg_sel_type s;
        s = SEL_NONE;
        if (a == ADDR_LIMIT) begin
            s = SEL_LIMIT;
        end else if (a == ADDR_SPEED) begin
            s = SEL_SPEED;
        end else if (a == ADDR_CSR) begin
            s = SEL_CSR;
        end else if (a == ADDR_ENABLE) begin
            s = SEL_EN;
        end
        return s;
    endfunction

    // ==========================================
    // next-state logic

    // whole block: bus slave, timebase, filter and measurement
    always_comb begin
        d = q;
        csr_rd = '0;
        // three-stage input synchroniser, level taken when stages agree
        d.sync = {q.sync[1:0], tach_pulse_input};
        if (q.sync[2] == q.sync[1]) begin
            d.level = q.sync[2];
        end
        // 32 kHz timebase and slow counter clock from it
        ftick = (q.pre == TICK_LAST);
        d.pre = ftick ? 12'h000 : q.pre + 12'h001;
        if (ftick) begin
            d.div = q.div + 4'h1;
        end
        div_mask = 4'((5'h02 << q.clksel) - 5'h01);
        cnt_tick = ftick && ((q.div & div_mask) == div_mask);
        // glitch filter: input must differ for a full window to pass
        if (q.level == q.filt) begin
            d.fcnt = 5'h00;
        end else if (ftick) begin
            if (q.fcnt == FILT_LAST) begin
                d.filt = q.level;
                d.fcnt = 5'h00;
            end else begin
                d.fcnt = q.fcnt + 5'h01;
            end
        end
        clean = q.filt_dis ? q.level : q.filt;
        d.prev = clean;
        rise = clean && !q.prev;

        // bus handshakes
        aw_fire = axi_req.awvalid && q.rsp.awready;
        w_fire = axi_req.wvalid && q.rsp.wready;
        ar_fire = axi_req.arvalid && q.rsp.arready;
        wr_fire = q.aw_got && q.w_got && !q.rsp.bvalid;
        wsel = reg_sel(q.awaddr);
        rsel = reg_sel(axi_req.araddr);
        wr_ok = wr_fire && q.wstrb0;
        rd_speed = ar_fire && (rsel == SEL_SPEED);
        if (aw_fire) begin
            d.aw_got = 1'b1;
            d.awaddr = axi_req.awaddr;
        end
        if (w_fire) begin
            d.w_got = 1'b1;
            d.wdata = axi_req.wdata[7:0];
            d.wstrb0 = axi_req.wstrb[0];
        end
        if (q.rsp.bvalid && axi_req.bready) begin
            d.rsp.bvalid = 1'b0;
        end
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end

        // register writes; status clears come before hardware sets
        if (wr_ok && wsel == SEL_LIMIT) begin
            d.limit = q.wdata;
        end
        if (wr_ok && wsel == SEL_EN) begin
            d.en = q.wdata[EN_BIT];
        end
        if (wr_ok && wsel == SEL_CSR) begin
            d.clksel = q.wdata[CSR_SEL_LSB +: 2];
            d.filt_dis = q.wdata[CSR_FILT_DIS];
            d.ie = q.wdata[CSR_IE];
            if (q.wdata[CSR_OVTH]) begin
                d.ovth = 1'b0;
            end
            if (q.wdata[CSR_OVF] && q.ovf) begin
                d.ovf = 1'b0;
                d.cnt = 8'h00;
                d.mon = MON_ARM;
            end
        end
        // frozen reading is released by a read once the flag is gone
        if (rd_speed && !d.ovth) begin
            d.block = 1'b0;
        end
        if (rd_speed) begin
            d.rdy = 1'b0;
        end

        // measurement
        ovf_evt = q.en && q.mon != MON_OFF && !q.ovf && cnt_tick
            && q.cnt == CNT_MAX;
        latch = q.mon == MON_RUN && rise && !q.ovth && !q.block && !q.ovf;
        if (ovf_evt) begin
            d.ovf = 1'b1;
            d.speed = SPEED_RST;
            d.rdy = 1'b0;
        end else if (q.mon == MON_ARM && rise) begin
            d.cnt = 8'h00;
            d.mon = MON_RUN;
        end else if (latch) begin
            d.speed = q.cnt;
            d.cnt = 8'h00;
            d.rdy = 1'b1;
            if (q.cnt > q.limit) begin
                d.ovth = 1'b1;
                d.block = 1'b1;
            end
        end else if (cnt_tick && !q.ovf && q.mon != MON_OFF) begin
            d.cnt = q.cnt + 8'h01;
        end
        // disabled: counter and reading held at zero
        if (!d.en) begin
            d.cnt = 8'h00;
            d.speed = SPEED_RST;
            d.mon = MON_OFF;
        end else if (q.mon == MON_OFF) begin
            d.mon = MON_ARM;
        end
        d.irq = q.ie && (q.ovth || q.ovf);

        // read channel
        csr_rd[CSR_SEL_LSB +: 2] = q.clksel;
        csr_rd[CSR_FILT_DIS] = q.filt_dis;
        csr_rd[CSR_IE] = q.ie;
        csr_rd[CSR_OVF] = q.ovf;
        csr_rd[CSR_OVTH] = q.ovth;
        csr_rd[CSR_RDY] = q.rdy;
        if (q.rsp.rvalid && axi_req.rready) begin
            d.rsp.rvalid = 1'b0;
        end
        if (ar_fire) begin
            d.rsp.rvalid = 1'b1;
            d.rsp.rresp = RESP_OKAY;
            d.rsp.rdata = 32'h0000_0000;
            if (rsel == SEL_LIMIT) begin
                d.rsp.rdata[7:0] = q.limit;
            end else if (rsel == SEL_SPEED) begin
                d.rsp.rdata[7:0] = q.speed;
            end else if (rsel == SEL_CSR) begin
                d.rsp.rdata[7:0] = csr_rd;
            end else if (rsel == SEL_EN) begin
                d.rsp.rdata[EN_BIT] = q.en;
            end else begin
                d.rsp.rresp = RESP_SLVERR;
            end
        end
        d.rsp.awready = !d.aw_got && !d.rsp.bvalid;
        d.rsp.wready = !d.w_got && !d.rsp.bvalid;
        d.rsp.arready = !d.rsp.rvalid;
    end

    // ==========================================
    // state register

    // synchronous reset to documented defaults
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.limit <= LIMIT_RST;
            q.clksel <= CLKSEL_RST;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign axi_rsp = q.rsp;
    assign speed_alert_irq = q.irq;

    // ==========================================
    // checks

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    hold_zero_a: assert property (
        !q.en |=> q.cnt == 8'h00 && q.speed == SPEED_RST)
        else $error("counter or reading not zero while disabled");

    cnt_step_a: assert property (
        cnt_tick && q.en && q.mon != MON_OFF && !q.ovf && !rise
            && !wr_fire && q.cnt != CNT_MAX
        |=> q.cnt == $past(q.cnt) + 8'h01)
        else $error("counter did not step on its clock");

    latch_a: assert property (
        latch && !ovf_evt && !wr_fire
        |=> q.speed == $past(q.cnt) && q.rdy && q.cnt == 8'h00)
        else $error("edge did not latch the count");

    read_clear_a: assert property (
        rd_speed && !latch |=> !q.rdy)
        else $error("speed read left ready set");

    over_thr_a: assert property (
        latch && !ovf_evt && q.cnt > q.limit
        |=> q.ovth ##1 q.irq == $past(q.ie))
        else $error("over-limit reading not flagged");

    hold_speed_a: assert property (
        q.ovth && q.en && !ovf_evt && !wr_fire |=> $stable(q.speed))
        else $error("reading changed while over-threshold");

    ovf_set_a: assert property (
        ovf_evt |=> q.ovf && q.speed == SPEED_RST && !q.rdy)
        else $error("overflow not handled");

    w1c_keep_a: assert property (
        wr_ok && wsel == SEL_CSR && !q.wdata[CSR_OVF] && q.ovf |=> q.ovf)
        else $error("writing zero cleared overflow");

    irq_out_a: assert property (
        q.ie && (q.ovth || q.ovf) |=> speed_alert_irq)
        else $error("interrupt not raised");

    filter_pass_a: assert property (
        !$stable(q.filt) |-> $past(q.fcnt) == FILT_LAST && $past(ftick))
        else $error("filter passed a short pulse");

    irq_quiet_a: assert property (
        !q.ie || (!q.ovth && !q.ovf) |=> !speed_alert_irq)
        else $error("interrupt raised without a flag");

    first_edge_a: assert property (
        q.en && q.mon == MON_ARM && rise && !ovf_evt && !wr_fire
        |=> $stable(q.speed) && q.cnt == 8'h00)
        else $error("first edge after enabling latched a reading");

    ovf_clear_a: assert property (
        wr_ok && wsel == SEL_CSR && q.wdata[CSR_OVF] && q.ovf && q.en
        |=> !q.ovf && q.cnt == 8'h00 && q.mon == MON_ARM)
        else $error("overflow clear did not restart measuring");

endmodule

// File: tb/fan_tach_model.sv
`timescale 1ns/1ps
// ==========================================
// fan tachometer: idle low, one pulse per call
module fan_tach_model (
    input wire logic aclk,
    output logic tach
);
    initial tach = 1'b0;

    // pulse high for hi cycles, moved just after rising edges
    task automatic emit(input int hi);
        tach <= 1'b1;
        repeat (hi) @(posedge aclk);
        tach <= 1'b0;
    endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import fan_monitor_pkg::*;
    // ==========================================
    // clock, reset, design and fan
    localparam int T16 = 6250;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    axi_req_type req;
    axi_rsp_type rsp;
    logic tach;
    logic irq;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 52;

    // 100 MHz clock
    initial begin
        forever #5 aclk = ~aclk;
    end

    fan_tach_speed_monitor dut_u (
        .aclk(aclk),
        .aresetn(aresetn),
        .axi_req(req),
        .axi_rsp(rsp),
        .tach_pulse_input(tach),
        .speed_alert_irq(irq)
    );

    fan_tach_model fan_u (
        .aclk(aclk),
        .tach(tach)
    );

    // ==========================================
    // helpers
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [7:0] got, input int lo, input int hi);
        checks_done++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            failures++;
            $display("mismatch at %0t: reading %h out of range", $time, got);
        end
    endtask

    // expected control/status byte; f is filter-off, irq-on, over, ready
    function automatic logic [7:0] csr_of(logic [1:0] sel, logic [3:0] f);
        return {1'b0, sel, f[3:2], 1'b0, f[1:0]};
    endfunction

    // axi4-lite write, bready held high throughout
    task automatic wr(input logic [31:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        req.awaddr <= a;
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        r = rsp.bresp;
    endtask

    // axi4-lite read, rready held high throughout
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        d = rsp.rdata;
        r = rsp.rresp;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk({r, d}, {RESP_OKAY, 24'h0, e});
    endtask

    // next tach rise comes cyc cycles after the previous one
    task automatic gap(input int cyc, input int hi);
        repeat (cyc - hi) @(posedge aclk);
        fan_u.emit(hi);
    endtask

    // run limit
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            $display("mismatch at %0t: run timed out", $time);
            report_and_stop();
        end
    end

    // ==========================================
    // main sequence
    initial begin
        logic [31:0] d;
        logic [31:0] bad;
        logic [7:0] lim;
        logic [7:0] frz;
        logic [1:0] r;
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(ADDR_LIMIT, LIMIT_RST);
        rd_chk(ADDR_SPEED, SPEED_RST);
        rd_chk(ADDR_CSR, csr_of(CLKSEL_RST, 4'b0000));
        lim = 8'($random(seed));
        wr(ADDR_LIMIT, lim, r);
        rd_chk(ADDR_LIMIT, lim);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_CSR, csr_of(2'(s), 4'b0000), r);
            rd_chk(ADDR_CSR, csr_of(2'(s), 4'b0000));
        end
        // unmapped word answers with an error and zero data
        bad = 32'h10 + 32'(({$random(seed)} % 60) * 4);
        rd(bad, d, r);
        chk({r, d}, {RESP_SLVERR, 32'h0});
        wr(bad, 8'hff, r);
        chk(34'(r), 34'(RESP_SLVERR));
        // limit set while disabled; writes to it are taken while enabled too
        wr(ADDR_LIMIT, 8'h02, r);
        wr(ADDR_CSR, csr_of(2'h0, 4'b1100), r);
        wr(ADDR_ENABLE, 8'h01, r);
        gap(300, 200);
        gap(T16, 200);
        rd_chk(ADDR_CSR, csr_of(2'h0, 4'b1101));
        rd(ADDR_SPEED, d, r);
        chk_rng(d[7:0], 0, 2);
        rd_chk(ADDR_CSR, csr_of(2'h0, 4'b1100));
        // slow interval goes over the limit and freezes the reading
        gap(4 * T16, 200);
        rd_chk(ADDR_CSR, csr_of(2'h0, 4'b1111));
        chk(34'(irq), 34'h1);
        rd(ADDR_SPEED, d, r);
        chk_rng(d[7:0], 3, 5);
        frz = d[7:0];
        // counter runs on while frozen: short gaps keep the resumed
        // interval under the limit
        gap(1000, 200);
        rd_chk(ADDR_SPEED, frz);
        wr(ADDR_CSR, csr_of(2'h0, 4'b1000), r);
        rd_chk(ADDR_CSR, csr_of(2'h0, 4'b1010));
        chk(34'(irq), 34'h0);
        wr(ADDR_CSR, csr_of(2'h0, 4'b1110), r);
        rd_chk(ADDR_CSR, csr_of(2'h0, 4'b1100));
        chk(34'(irq), 34'h0);
        gap(1000, 200);
        rd_chk(ADDR_SPEED, frz);
        gap(1000, 200);
        rd_chk(ADDR_CSR, csr_of(2'h0, 4'b1101));
        rd(ADDR_SPEED, d, r);
        chk_rng(d[7:0], 0, 2);
        // a full interval leaves a non-zero reading, then disabling clears it
        gap(T16, 200);
        wr(ADDR_ENABLE, 8'h00, r);
        rd_chk(ADDR_SPEED, 8'h00);
        // filter on: short pulses never reach the edge detector
        wr(ADDR_CSR, csr_of(2'h0, 4'b0100), r);
        wr(ADDR_ENABLE, 8'h01, r);
        repeat (3) gap(2000, 300);
        rd_chk(ADDR_CSR, csr_of(2'h0, 4'b0100));
        rd_chk(ADDR_SPEED, 8'h00);
        report_and_stop();
    end
endmodule
